// [pkg/slwp_regs.svh]
// Timing and sizing constants of the status LED, wake and pin logic.
// Included by the blink timer and the top-level pin logic; holds definitions only.
`ifndef SLWP_REGS_SVH
`define SLWP_REGS_SVH
`define SLWP_CLK_HZ 100000000
`define SLWP_XTAL_HZ 25000000
`define SLWP_MS_PER_S 1000
`define SLWP_BLINK_MS 80
`define SLWP_GPIO_NUM 3
`define SLWP_CNT_W 24
`define SLWP_LED_SPEED 0
`define SLWP_LED_LINK 1
`define SLWP_LED_DUPLEX 2
`define SLWP_BLINK_CYCLES (`SLWP_BLINK_MS * (`SLWP_CLK_HZ / `SLWP_MS_PER_S))
`endif

// [pkg/slwp_pkg.sv]
// Types shared by the status LED, wake and pin logic.
// Assumes nothing of its surroundings.
`default_nettype none
package slwp_pkg;
  typedef enum logic [1:0] {
    SLWP_PIN_INPUT = 2'h0,
    SLWP_PIN_PUSH_PULL = 2'h1,
    SLWP_PIN_OPEN_DRAIN = 2'h2
  } slwp_gpio_mode_t;

  typedef enum logic [1:0] {
    SLWP_CLK_MEM = 2'h0,
    SLWP_CLK_GPO = 2'h1,
    SLWP_CLK_RX_DV = 2'h2,
    SLWP_CLK_RX_CLK = 2'h3
  } slwp_clk_sel_t;

  typedef enum logic [1:0] {
    SLWP_BL_IDLE = 2'h0,
    SLWP_BL_DARK = 2'h1,
    SLWP_BL_HOLD = 2'h3
  } slwp_blink_state_t;
endpackage
`default_nettype wire

// [logic/slwp_pin.sv]
// Registered output cell for one pad: push-pull, open-drain or input,
// with an LED override that is always open-drain.
// Assumes the caller resolves the pad level from out and oe.
`timescale 1ns/1ps
`default_nettype none
module slwp_pin (
  input wire logic clock_i,
  input wire logic rst_i,
  input wire slwp_pkg::slwp_gpio_mode_t mode_i,
  input wire logic led_en_i,
  input wire logic led_on_i,
  input wire logic data_i,
  output logic pad_o,
  output logic pad_oe_o
);
  always_ff @(posedge clock_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      pad_o <= 1'b0;
      pad_oe_o <= 1'b0;
    end
    else if (led_en_i)
    begin
      // Pull low for on, release for off
      pad_o <= 1'b0;
      pad_oe_o <= led_on_i;
    end
    else
    begin
      unique case (mode_i)
        slwp_pkg::SLWP_PIN_PUSH_PULL:
        begin
          pad_o <= data_i;
          pad_oe_o <= 1'b1;
        end
        slwp_pkg::SLWP_PIN_OPEN_DRAIN:
        begin
          pad_o <= 1'b0;
          pad_oe_o <= ~data_i;
        end
        default:
        begin
          pad_o <= 1'b0;
          pad_oe_o <= 1'b0;
        end
      endcase
    end
  end
endmodule
`default_nettype wire

// [logic/slwp_blink.sv]
// Activity blink timer for the link/activity LED: dark phase then
// a lit hold phase, each BLINK_CYCLES long, repeated while activity lasts.
// Assumes activity_i is a level or pulse synchronous to clock_i.
`timescale 1ns/1ps
`default_nettype none
`include "slwp_regs.svh"
module slwp_blink #(
  parameter int unsigned BLINK_CYCLES = `SLWP_BLINK_CYCLES,
  parameter int unsigned CNT_W = `SLWP_CNT_W
) (
  input wire logic clock_i,
  input wire logic rst_i,
  input wire logic link_up_i,
  input wire logic activity_i,
  output logic dark_o
);
  if (BLINK_CYCLES < 1 || BLINK_CYCLES > (64'h1 << CNT_W))
  begin : g_bad_len
    $error("slwp_blink: BLINK_CYCLES does not fit CNT_W");
  end

  localparam logic [CNT_W-1:0] LAST = CNT_W'(BLINK_CYCLES - 1);

  slwp_pkg::slwp_blink_state_t state;
  logic [CNT_W-1:0] cnt;
  logic pending;
  logic cnt_done;

  assign cnt_done = (cnt == LAST);
  assign dark_o = (state == slwp_pkg::SLWP_BL_DARK);

  // Phase sequencing; no link stops blinking at once
  always_ff @(posedge clock_i or posedge rst_i)
  begin
    if (rst_i)
      state <= slwp_pkg::SLWP_BL_IDLE;
    else if (!link_up_i)
      state <= slwp_pkg::SLWP_BL_IDLE;
    else
    begin
      unique case (state)
        slwp_pkg::SLWP_BL_IDLE:
          if (activity_i)
            state <= slwp_pkg::SLWP_BL_DARK;
        slwp_pkg::SLWP_BL_DARK:
          if (cnt_done)
            state <= slwp_pkg::SLWP_BL_HOLD;
        slwp_pkg::SLWP_BL_HOLD:
          if (cnt_done)
            state <= (pending || activity_i) ? slwp_pkg::SLWP_BL_DARK : slwp_pkg::SLWP_BL_IDLE;
        default:
          state <= slwp_pkg::SLWP_BL_IDLE;
      endcase
    end
  end

  // Phase length counter
  always_ff @(posedge clock_i or posedge rst_i)
  begin
    if (rst_i)
      cnt <= '0;
    else if (!link_up_i || state == slwp_pkg::SLWP_BL_IDLE || cnt_done)
      cnt <= '0;
    else
      cnt <= cnt + CNT_W'(1);
  end

  // Activity seen during a blink starts the next one
  always_ff @(posedge clock_i or posedge rst_i)
  begin
    if (rst_i)
      pending <= 1'b0;
    else if (!link_up_i)
      pending <= 1'b0;
    else if (state == slwp_pkg::SLWP_BL_HOLD && cnt_done)
      pending <= 1'b0;
    else if (activity_i && state != slwp_pkg::SLWP_BL_IDLE)
      pending <= 1'b1;
  end
endmodule
`default_nettype wire

// [logic/slwp_top.sv]
// Pin logic: three GPIO lines with LED functions, the wake indicator,
// host wake and write gating, and the shared serial-memory clock pin.
// Assumes all inputs are synchronous to clock_i; clock_i is derived
// from the crystal reference; pad levels are resolved outside.
// Behaviour
// - Clock pin selects memory clock, output, monitors
// - Memory select inactive unless memory clock mode
// - Core timing from 25MHz crystal reference
// - Reset input low clears all state
// - Enabled wake event asserts wake indicator
// - Wake polarity and drive type are configurable
// - Only host write leaves power saving
// - Each GPIO is input, push-pull or open-drain
// - LED function drives pin open-drain only
// - Speed LED high only at 10Mbs link
// - Link LED low while link valid
// - Activity blinks 80ms dark, 80ms lit minimum
// - Duplex LED low in full duplex
`timescale 1ns/1ps
`default_nettype none
`include "slwp_regs.svh"
module slwp_top #(
  parameter int unsigned CLK_HZ = `SLWP_CLK_HZ,
  parameter int unsigned GPIO_NUM = `SLWP_GPIO_NUM,
  parameter int unsigned BLINK_CYCLES = `SLWP_BLINK_MS * (CLK_HZ / `SLWP_MS_PER_S)
) (
  input wire logic clock_i,
  input wire logic rst_i,
  input wire logic reset_in_n_i,
  input wire logic host_select_n_i,
  input wire logic host_write_strobe_n_i,
  input wire logic host_read_strobe_n_i,
  input wire logic power_save_req_i,
  output logic host_write_accept_o,
  output logic read_seen_o,
  output logic asleep_o,
  input wire logic wake_enable_i,
  input wire logic wake_polarity_i,
  input wire logic wake_open_drain_i,
  input wire logic wake_event_i,
  input wire logic wake_clear_i,
  output logic wake_pending_o,
  output logic wake_indicator_o,
  output logic wake_indicator_oe_o,
  input wire logic [2*GPIO_NUM-1:0] gpio_mode_i,
  input wire logic [GPIO_NUM-1:0] gpio_led_en_i,
  input wire logic [GPIO_NUM-1:0] gpio_data_i,
  input wire logic [GPIO_NUM-1:0] gpio_pad_i,
  output logic [GPIO_NUM-1:0] gpio_in_o,
  output logic [GPIO_NUM-1:0] gpio_pad_o,
  output logic [GPIO_NUM-1:0] gpio_pad_oe_o,
  input wire logic link_up_i,
  input wire logic speed_10_i,
  input wire logic autoneg_busy_i,
  input wire logic full_duplex_i,
  input wire logic activity_i,
  output logic speed_led_n_o,
  output logic link_activity_led_n_o,
  output logic duplex_led_n_o,
  input wire slwp_pkg::slwp_clk_sel_t clk_pin_sel_i,
  input wire logic mem_clock_i,
  input wire logic mem_select_i,
  input wire logic general_output_four_i,
  input wire logic rx_dv_i,
  input wire logic rx_clk_i,
  output logic serial_mem_clock_pin_o,
  output logic serial_mem_select_o
);
  // Core clock must be a whole multiple of the crystal reference
  if (CLK_HZ % `SLWP_XTAL_HZ != 0 || CLK_HZ < `SLWP_XTAL_HZ)
  begin : g_bad_clk
    $error("slwp_top: CLK_HZ is not a multiple of the crystal rate");
  end
  if (GPIO_NUM != `SLWP_GPIO_NUM)
  begin : g_bad_gpio
    $error("slwp_top: LED mapping needs exactly three GPIO lines");
  end
  if (BLINK_CYCLES < 1)
  begin : g_bad_blink
    $error("slwp_top: BLINK_CYCLES must be at least one");
  end

  logic core_rst;
  logic host_write;
  logic host_read;
  logic wake_level;
  logic blink_dark;
  logic [GPIO_NUM-1:0] led_n;

  // External reset pin and power-on reset both clear everything
  assign core_rst = rst_i | ~reset_in_n_i;
  assign host_write = ~host_select_n_i & ~host_write_strobe_n_i;
  assign host_read = ~host_select_n_i & ~host_read_strobe_n_i;

  // Power state: the wake indicator plays no part here
  always_ff @(posedge clock_i or posedge core_rst)
  begin
    if (core_rst)
      asleep_o <= 1'b0;
    else if (host_write)
      asleep_o <= 1'b0;
    else if (power_save_req_i)
      asleep_o <= 1'b1;
  end

  // Read gate, cleared on power saving request and while asleep
  always_ff @(posedge clock_i or posedge core_rst)
  begin
    if (core_rst)
      read_seen_o <= 1'b0;
    else if (asleep_o || power_save_req_i)
      read_seen_o <= 1'b0;
    else if (host_read)
      read_seen_o <= 1'b1;
  end

  always_ff @(posedge clock_i or posedge core_rst)
  begin
    if (core_rst)
      host_write_accept_o <= 1'b0;
    else
      host_write_accept_o <= host_write & read_seen_o & ~asleep_o;
  end

  // Sticky wake request; a new event beats a clear
  always_ff @(posedge clock_i or posedge core_rst)
  begin
    if (core_rst)
      wake_pending_o <= 1'b0;
    else if (wake_enable_i && wake_event_i)
      wake_pending_o <= 1'b1;
    else if (wake_clear_i || !wake_enable_i)
      wake_pending_o <= 1'b0;
  end

  assign wake_level = wake_pending_o ~^ wake_polarity_i;

  slwp_pin u_wake_pin (
    .clock_i(clock_i),
    .rst_i(core_rst),
    .mode_i(wake_open_drain_i ? slwp_pkg::SLWP_PIN_OPEN_DRAIN : slwp_pkg::SLWP_PIN_PUSH_PULL),
    .led_en_i(1'b0),
    .led_on_i(1'b0),
    .data_i(wake_level),
    .pad_o(wake_indicator_o),
    .pad_oe_o(wake_indicator_oe_o)
  );

  slwp_blink #(
    .BLINK_CYCLES(BLINK_CYCLES)
  ) u_blink (
    .clock_i(clock_i),
    .rst_i(core_rst),
    .link_up_i(link_up_i),
    .activity_i(activity_i),
    .dark_o(blink_dark)
  );

  // Indicator levels, low means lit
  always_ff @(posedge clock_i or posedge core_rst)
  begin
    if (core_rst)
    begin
      speed_led_n_o <= 1'b0;
      link_activity_led_n_o <= 1'b1;
      duplex_led_n_o <= 1'b1;
    end
    else
    begin
      speed_led_n_o <= link_up_i & speed_10_i & ~autoneg_busy_i;
      link_activity_led_n_o <= ~link_up_i | blink_dark;
      duplex_led_n_o <= ~(link_up_i & full_duplex_i);
    end
  end

  assign led_n[`SLWP_LED_SPEED] = speed_led_n_o;
  assign led_n[`SLWP_LED_LINK] = link_activity_led_n_o;
  assign led_n[`SLWP_LED_DUPLEX] = duplex_led_n_o;

  for (genvar g = 0; g < GPIO_NUM; g++)
  begin : g_gpio
    slwp_pin u_pin (
      .clock_i(clock_i),
      .rst_i(core_rst),
      .mode_i(slwp_pkg::slwp_gpio_mode_t'(gpio_mode_i[2*g +: 2])),
      .led_en_i(gpio_led_en_i[g]),
      .led_on_i(~led_n[g]),
      .data_i(gpio_data_i[g]),
      .pad_o(gpio_pad_o[g]),
      .pad_oe_o(gpio_pad_oe_o[g])
    );

    always_ff @(posedge clock_i or posedge core_rst)
    begin
      if (core_rst)
        gpio_in_o[g] <= 1'b0;
      else
        gpio_in_o[g] <= gpio_pad_i[g];
    end
  end

  // Shared clock pin: output only; rx clock monitor is sampled
  always_ff @(posedge clock_i or posedge core_rst)
  begin
    if (core_rst)
    begin
      serial_mem_clock_pin_o <= 1'b0;
      serial_mem_select_o <= 1'b0;
    end
    else
    begin
      unique case (clk_pin_sel_i)
        slwp_pkg::SLWP_CLK_MEM:
          serial_mem_clock_pin_o <= mem_clock_i;
        slwp_pkg::SLWP_CLK_GPO:
          serial_mem_clock_pin_o <= general_output_four_i;
        slwp_pkg::SLWP_CLK_RX_DV:
          serial_mem_clock_pin_o <= rx_dv_i;
        slwp_pkg::SLWP_CLK_RX_CLK:
          serial_mem_clock_pin_o <= rx_clk_i;
      endcase
      serial_mem_select_o <= mem_select_i & (clk_pin_sel_i == slwp_pkg::SLWP_CLK_MEM);
    end
  end

  // Checks
  logic [31:0] dark_len;
  always_ff @(posedge clock_i or posedge core_rst)
  begin
    if (core_rst)
      dark_len <= '0;
    else if (blink_dark)
      dark_len <= dark_len + 32'h1;
    else
      dark_len <= '0;
  end

  sequence s_wake_set;
    wake_enable_i && wake_event_i;
  endsequence

  sequence s_wake_shown;
    wake_pending_o ##1 (wake_indicator_o == wake_polarity_i || !wake_indicator_oe_o);
  endsequence

  property p_select_quiet;
    @(posedge clock_i) disable iff (core_rst)
    clk_pin_sel_i != slwp_pkg::SLWP_CLK_MEM |=> !serial_mem_select_o;
  endproperty
  a_select_quiet: assert property (p_select_quiet) else $error("memory select active outside memory mode");

  property p_gpo_follow;
    @(posedge clock_i) disable iff (core_rst)
    clk_pin_sel_i == slwp_pkg::SLWP_CLK_GPO |=> serial_mem_clock_pin_o == $past(general_output_four_i);
  endproperty
  a_gpo_follow: assert property (p_gpo_follow) else $error("clock pin does not follow general output");

  property p_reset_pin;
    @(posedge clock_i) disable iff (rst_i)
    !reset_in_n_i |-> !wake_pending_o && !asleep_o && !read_seen_o;
  endproperty
  a_reset_pin: assert property (p_reset_pin) else $error("state survives reset pin");

  property p_write_gate;
    @(posedge clock_i) disable iff (core_rst)
    host_write && !read_seen_o |=> !host_write_accept_o;
  endproperty
  a_write_gate: assert property (p_write_gate) else $error("write accepted before first read");

  property p_wake_out;
    @(posedge clock_i) disable iff (core_rst)
    s_wake_set ##1 (wake_enable_i && !wake_event_i) |-> s_wake_shown;
  endproperty
  a_wake_out: assert property (p_wake_out) else $error("wake event not shown on indicator");

  property p_wake_pp;
    @(posedge clock_i) disable iff (core_rst)
    !$past(core_rst) && !wake_open_drain_i && $stable(wake_open_drain_i) && $stable(wake_polarity_i)
      && $stable(wake_pending_o)
      |=> wake_indicator_oe_o && wake_indicator_o == ($past(wake_pending_o) ~^ $past(wake_polarity_i));
  endproperty
  a_wake_pp: assert property (p_wake_pp) else $error("wake polarity wrong in push-pull");

  property p_sleep_hold;
    @(posedge clock_i) disable iff (core_rst)
    asleep_o && !host_write |=> asleep_o;
  endproperty
  a_sleep_hold: assert property (p_sleep_hold) else $error("left power saving without host write");

  property p_od_line;
    @(posedge clock_i) disable iff (core_rst)
    !gpio_led_en_i[0] && gpio_mode_i[1:0] == slwp_pkg::SLWP_PIN_OPEN_DRAIN && gpio_data_i[0]
      |=> !gpio_pad_oe_o[0];
  endproperty
  a_od_line: assert property (p_od_line) else $error("open-drain line driven high");

  property p_led_od;
    @(posedge clock_i) disable iff (core_rst)
    gpio_led_en_i[1] |=> !gpio_pad_o[1] && gpio_pad_oe_o[1] == !$past(link_activity_led_n_o);
  endproperty
  a_led_od: assert property (p_led_od) else $error("LED line not open-drain");

  property p_speed;
    @(posedge clock_i) disable iff (core_rst)
    (!link_up_i || !speed_10_i || autoneg_busy_i) |=> !speed_led_n_o;
  endproperty
  a_speed: assert property (p_speed) else $error("speed LED high outside 10Mbs link");

  property p_link_idle;
    @(posedge clock_i) disable iff (core_rst)
    link_up_i && !blink_dark |=> !link_activity_led_n_o;
  endproperty
  a_link_idle: assert property (p_link_idle) else $error("link LED dark with idle link");

  property p_dark_len;
    @(posedge clock_i) disable iff (core_rst)
    $fell(blink_dark) && $past(link_up_i) && link_up_i |-> dark_len == BLINK_CYCLES;
  endproperty
  a_dark_len: assert property (p_dark_len) else $error("blink dark phase wrong length");

  property p_duplex;
    @(posedge clock_i) disable iff (core_rst)
    link_up_i && full_duplex_i ##1 link_up_i && full_duplex_i |-> !duplex_led_n_o;
  endproperty
  a_duplex: assert property (p_duplex) else $error("duplex LED off in full duplex");

  property p_no_link;
    @(posedge clock_i) disable iff (core_rst)
    !link_up_i |=> link_activity_led_n_o && !blink_dark;
  endproperty
  a_no_link: assert property (p_no_link) else $error("link LED lit without link");
endmodule
`default_nettype wire

// [tb/slwp_board.sv]
// Board model: pull-ups on the three GPIO pads and on the wake line,
// and an external driver for lines that the bench sets as inputs.
// Assumes a released pad floats to its pull-up level.
`timescale 1ns/1ps
`default_nettype none
module slwp_board (
  input wire logic [2:0] pad_i,
  input wire logic [2:0] oe_i,
  input wire logic [2:0] ext_en_i,
  input wire logic [2:0] ext_val_i,
  input wire logic wake_i,
  input wire logic wake_oe_i,
  output logic [2:0] level_o,
  output logic wake_level_o
);
  // Block drive wins, then external driver, else pull-up
  always_comb
  begin
    for (int k = 0; k < 3; k++)
      level_o[k] = oe_i[k] ? pad_i[k] : (ext_en_i[k] ? ext_val_i[k] : 1'b1);
  end
  assign wake_level_o = wake_oe_i ? wake_i : 1'b1;
endmodule
`default_nettype wire

// [tb/slwp_top_tb_top.sv]
// Self-checking bench of the pin logic, random stimulus with corner cases.
// Assumes the board model resolves pad levels with pull-ups.
`timescale 1ns/1ps
`default_nettype none
module slwp_top_tb_top;
  localparam int B = 10;
  logic clock_i = 1'b0;
  logic rst_i = 1'b1;
  logic reset_in_n_i = 1'b1;
  logic host_select_n_i = 1'b1;
  logic host_write_strobe_n_i = 1'b1;
  logic host_read_strobe_n_i = 1'b1;
  logic [3:0] pl = 4'h0;
  wire logic power_save_req_i, wake_event_i, wake_clear_i, activity_i;
  logic wake_enable_i = 1'b0;
  logic wake_polarity_i = 1'b0;
  logic wake_open_drain_i = 1'b0;
  logic [5:0] gpio_mode_i = 6'h00;
  logic [2:0] gpio_led_en_i = 3'h0;
  logic [2:0] gpio_data_i = 3'h0;
  logic [2:0] ext_val = 3'h0;
  logic [2:0] ext_en, gpio_pad_i, gpio_in_o, gpio_pad_o, gpio_pad_oe_o;
  logic link_up_i = 1'b0;
  logic speed_10_i = 1'b0;
  logic autoneg_busy_i = 1'b0;
  logic full_duplex_i = 1'b0;
  slwp_pkg::slwp_clk_sel_t clk_pin_sel_i = slwp_pkg::SLWP_CLK_MEM;
  logic [4:0] src5 = 5'h00;
  wire logic mem_clock_i, mem_select_i, general_output_four_i, rx_dv_i, rx_clk_i;
  logic host_write_accept_o, read_seen_o, asleep_o, wake_pending_o;
  logic wake_indicator_o, wake_indicator_oe_o, wake_level;
  logic speed_led_n_o, link_activity_led_n_o, duplex_led_n_o;
  logic serial_mem_clock_pin_o, serial_mem_select_o;
  int failures = 0;
  int samples_checked = 0;
  int c;
  logic [2:0] ex;
  logic [1:0] m;
  logic e;
  assign {activity_i, wake_clear_i, wake_event_i, power_save_req_i} = pl;
  assign {rx_clk_i, rx_dv_i, general_output_four_i, mem_select_i, mem_clock_i} = src5;
  // Lines in input mode are driven from outside
  assign ext_en = {gpio_mode_i[5] ~^ gpio_mode_i[4], gpio_mode_i[3] ~^ gpio_mode_i[2],
                   gpio_mode_i[1] ~^ gpio_mode_i[0]};

  slwp_top #(.BLINK_CYCLES(B)) slwp_top_inst (
    .clock_i, .rst_i, .reset_in_n_i, .host_select_n_i, .host_write_strobe_n_i,
    .host_read_strobe_n_i, .power_save_req_i, .host_write_accept_o, .read_seen_o,
    .asleep_o, .wake_enable_i, .wake_polarity_i, .wake_open_drain_i, .wake_event_i,
    .wake_clear_i, .wake_pending_o, .wake_indicator_o, .wake_indicator_oe_o,
    .gpio_mode_i, .gpio_led_en_i, .gpio_data_i, .gpio_pad_i, .gpio_in_o, .gpio_pad_o,
    .gpio_pad_oe_o, .link_up_i, .speed_10_i, .autoneg_busy_i, .full_duplex_i,
    .activity_i, .speed_led_n_o, .link_activity_led_n_o, .duplex_led_n_o,
    .clk_pin_sel_i, .mem_clock_i, .mem_select_i, .general_output_four_i, .rx_dv_i,
    .rx_clk_i, .serial_mem_clock_pin_o, .serial_mem_select_o
  );

  slwp_board slwp_board_inst (
    .pad_i(gpio_pad_o), .oe_i(gpio_pad_oe_o), .ext_en_i(ext_en), .ext_val_i(ext_val),
    .wake_i(wake_indicator_o), .wake_oe_i(wake_indicator_oe_o),
    .level_o(gpio_pad_i), .wake_level_o(wake_level)
  );

  always #5 clock_i = ~clock_i;

  task automatic chk(input logic g, input logic x);
    samples_checked++;
    if (g !== x)
    begin
      failures++;
      $display("wrong value t=%0t got=%h exp=%h", $time, g, x);
    end
  endtask

  // Expected LED levels {duplex, link, speed} from {link, 10M, autoneg, full}
  function automatic logic [2:0] led_exp(input logic [3:0] s);
    return {~(s[3] & s[0]), ~s[3], s[3] & s[2] & ~s[1]};
  endfunction

  // Pad level: driven data in output modes, else the outside driver
  function automatic logic pin_exp(input logic [1:0] md, input logic d, input logic x);
    return (md == 2'h1 || md == 2'h2) ? d : x;
  endfunction

  task automatic st(input int n);
    repeat (n) @(posedge clock_i);
    @(negedge clock_i);
  endtask

  task automatic host(input logic wr);
    @(posedge clock_i);
    host_select_n_i <= 1'b0;
    host_write_strobe_n_i <= ~wr;
    host_read_strobe_n_i <= wr;
    @(posedge clock_i);
    host_select_n_i <= 1'b1;
    host_write_strobe_n_i <= 1'b1;
    host_read_strobe_n_i <= 1'b1;
    @(negedge clock_i);
  endtask

  task automatic pulse(input int k);
    @(posedge clock_i);
    pl[k] <= 1'b1;
    @(posedge clock_i);
    pl[k] <= 1'b0;
    @(negedge clock_i);
  endtask

  task automatic run(input logic v, input int lim, output int n);
    n = 0;
    while (link_activity_led_n_o === v && n < lim)
    begin
      @(negedge clock_i);
      n++;
    end
  endtask

  task automatic rchk();
    chk(read_seen_o | asleep_o | wake_pending_o | host_write_accept_o, 1'b0);
    chk(link_activity_led_n_o & duplex_led_n_o & ~speed_led_n_o, 1'b1);
    chk(|gpio_pad_oe_o | wake_indicator_oe_o | serial_mem_clock_pin_o | serial_mem_select_o, 1'b0);
  endtask

  task automatic end_sim();
    $display("comparisons %0d mismatches %0d", samples_checked, failures);
    if (failures == 0 && samples_checked > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  initial
  begin
    repeat (500 * B) @(posedge clock_i);
    failures++;
    end_sim();
  end

  initial
  begin
    void'($urandom(32'hBED56BF5));
    st(11);
    rchk();
    @(posedge clock_i);
    rst_i <= 1'b0;
    $display("test reset done");
    // Host gating and sleep
    host(1'b1);
    chk(host_write_accept_o, 1'b0);
    host(1'b0);
    chk(read_seen_o, 1'b1);
    host(1'b1);
    chk(host_write_accept_o, 1'b1);
    st(0);
    chk(host_write_accept_o, 1'b0);
    pulse(0);
    chk(asleep_o & ~read_seen_o, 1'b1);
    @(posedge clock_i);
    wake_enable_i <= 1'b1;
    pulse(1);
    st(2);
    chk(asleep_o & wake_pending_o, 1'b1);
    host(1'b1);
    chk(asleep_o | host_write_accept_o, 1'b0);
    host(1'b1);
    chk(host_write_accept_o, 1'b0);
    host(1'b0);
    host(1'b1);
    chk(host_write_accept_o, 1'b1);
    $display("test host done");
    // Wake indicator in every polarity and drive type
    for (int i = 0; i < 4; i++)
    begin
      @(posedge clock_i);
      wake_polarity_i <= i[0];
      wake_open_drain_i <= i[1];
      pulse(2);
      st(1);
      chk(wake_pending_o, 1'b0);
      chk(wake_level, ~i[0]);
      pulse(1);
      chk(wake_pending_o, 1'b1);
      st(1);
      chk(wake_level, i[0]);
      chk(wake_indicator_oe_o | i[1], 1'b1);
    end
    pulse(2);
    @(posedge clock_i);
    wake_enable_i <= 1'b0;
    pulse(1);
    st(1);
    chk(wake_pending_o, 1'b0);
    $display("test wake done");
    for (int n = 0; n < 40; n++)
    begin
      @(posedge clock_i);
      gpio_mode_i <= 6'($urandom);
      gpio_data_i <= 3'($urandom);
      ext_val <= 3'($urandom);
      st(2);
      for (int k = 0; k < 3; k++)
      begin
        m = gpio_mode_i[2*k+:2];
        e = pin_exp(m, gpio_data_i[k], ext_val[k]);
        chk(gpio_pad_i[k], e);
        chk(gpio_in_o[k], e);
        chk(gpio_pad_oe_o[k], m == 2'h1 || (m == 2'h2 && !gpio_data_i[k]));
      end
    end
    $display("test gpio done");
    @(posedge clock_i);
    gpio_mode_i <= 6'h15;
    gpio_led_en_i <= 3'h7;
    for (int n = 0; n < 16; n++)
    begin
      @(posedge clock_i);
      {link_up_i, speed_10_i, autoneg_busy_i, full_duplex_i} <= 4'(n);
      st(2);
      ex = led_exp(4'(n));
      chk(speed_led_n_o, ex[0]);
      chk(link_activity_led_n_o, ex[1]);
      chk(duplex_led_n_o, ex[2]);
      for (int k = 0; k < 3; k++)
      begin
        chk(gpio_pad_i[k], ex[k]);
        chk(gpio_pad_oe_o[k], ~ex[k]);
        chk(gpio_pad_o[k] & gpio_pad_oe_o[k], 1'b0);
      end
    end
    $display("test led done");
    @(posedge clock_i);
    link_up_i <= 1'b1;
    st(3);
    pulse(3);
    run(1'b0, 10, c);
    run(1'b1, 4 * B, c);
    chk(c == B, 1'b1);
    run(1'b0, 2 * B, c);
    chk(c == 2 * B, 1'b1);
    @(posedge clock_i);
    pl[3] <= 1'b1;
    run(1'b0, 10, c);
    run(1'b1, 4 * B, c);
    chk(c == B, 1'b1);
    run(1'b0, 4 * B, c);
    chk(c >= B && c < 4 * B, 1'b1);
    @(posedge clock_i);
    link_up_i <= 1'b0;
    st(2);
    run(1'b1, 3 * B, c);
    chk(c == 3 * B, 1'b1);
    @(posedge clock_i);
    pl[3] <= 1'b0;
    $display("test blink done");
    for (int n = 0; n < 24; n++)
    begin
      @(posedge clock_i);
      clk_pin_sel_i <= slwp_pkg::slwp_clk_sel_t'(n[1:0]);
      src5 <= 5'($urandom);
      st(1);
      ex = n[1:0] == 2'h0 ? {2'h0, mem_clock_i} : {2'h0, src5[n[1:0] + 1]};
      chk(serial_mem_clock_pin_o, ex[0]);
      chk(serial_mem_select_o, n[1:0] == 2'h0 && mem_select_i);
    end
    $display("test clock pin done");
    @(posedge clock_i);
    wake_enable_i <= 1'b1;
    pulse(1);
    host(1'b0);
    @(posedge clock_i);
    reset_in_n_i <= 1'b0;
    st(1);
    rchk();
    @(posedge clock_i);
    reset_in_n_i <= 1'b1;
    host(1'b1);
    chk(host_write_accept_o, 1'b0);
    $display("test pin reset done");
    end_sim();
  end
endmodule
`default_nettype wire
